// ---- atsov_regs.vh ----
// constants for the angle tracker status and programmable-register verify block
// Behaviour
// - digital readback command returns programmable register
// - readback frame uses write/program bit layout
// - analog readback turns program pin into output
// - programmed bit low, unprogrammed bit high
// - wiring config bit follows input pin level
// - low three-wire or inner chain, high last
// - locked bit shown; unlocked angle invalid
// - weak field pin high only at gain 3F
// - angle frame carries gain code in D13:D7
// - four sensitivity steps, default lowest 00
// - converter steps once per 1.15 us cycle
// - lock within 127 steps, then track per cycle
// - stays locked up to 30000 rpm
// - reduced power freezes converter, resumes from hold
// - relock time is period times angle difference
// - sensitivity field 00 lowest, 11 highest
// - readback bits 7:0 hold zero position
// - power saving bit one selects frozen state
`ifndef ATSOV_REGS_VH
`define ATSOV_REGS_VH
// ****************************************************************
// command codes and frame layout
// ****************************************************************
`define ATSOV_CMD_RD_OTP      5'h0F
`define ATSOV_CMD_ANA_OTP     5'h09
`define ATSOV_CMD_RD_ANGLE    5'h10
`define ATSOV_OTP_BITS        18
`define ATSOV_OTP_MSB         17
`define ATSOV_SENS_HI         9
`define ATSOV_SENS_LO         8
`define ATSOV_ZERO_HI         7
`define ATSOV_OTP_RESET       18'h00000
`define ATSOV_ANG_FRAME_BITS  16
`define ATSOV_GAIN_MAX        6'h3F
// ****************************************************************
// register port map
// ****************************************************************
`define ATSOV_ADDR_CMD        4'h0
`define ATSOV_ADDR_CTRL       4'h1
`define ATSOV_ADDR_STATUS     4'h2
`define ATSOV_ADDR_ANGLE      4'h3
`define ATSOV_ADDR_OTP        4'h4
`define ATSOV_CTRL_PWRSAVE    0
`define ATSOV_ST_LOCK         0
`define ATSOV_ST_WIRE         1
`define ATSOV_ST_WEAK         2
`define ATSOV_ST_BUSY         3
// ****************************************************************
// timing
// ****************************************************************
`define ATSOV_TRACK_PS        1150000
`define ATSOV_CLK_PS          8000
`endif

// ---- atsov_top.v ----
// angle tracker status, lock logic and programmable-register readback
`timescale 1ns/1ps
`include "atsov_regs.vh"
module atsov_top #(
  parameter TRACK_CYC = `ATSOV_TRACK_PS / `ATSOV_CLK_PS
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata_ff,
  input  wire        linkClk,
  output reg         linkDataOut_ff,
  output reg         linkDataOe_b_ff,
  output reg         progPinOut_ff,
  output reg         progPinOe_b_ff,
  input  wire        wiringCfgPin,
  input  wire [7:0]  measAngle,
  input  wire [5:0]  gainCode,
  output reg         weakFieldFlag_ff,
  output reg [7:0]   angle_ff,
  output reg         locked_ff
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function [7:0] absDiff;
    input [7:0] a;
    input [7:0] b;
    begin
      absDiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // ****************************************************************
  // pin synchronisers: three stages, change once stages 2 and 3 agree
  // ****************************************************************
  reg [2:0] clkSync_ff;
  reg [2:0] wireSync_ff;
  reg       linkClkLvl_ff;
  reg       wiringCfgBit_ff;
  wire      linkRise = (clkSync_ff[1] == clkSync_ff[2]) && clkSync_ff[2] && !linkClkLvl_ff;
  always @(posedge clk) begin
    if (!rst_b) begin
      clkSync_ff      <= 3'h0;
      wireSync_ff     <= 3'h0;
      linkClkLvl_ff   <= 1'b0;
      wiringCfgBit_ff <= 1'b0;
    end else begin
      clkSync_ff  <= {clkSync_ff[1:0], linkClk};
      wireSync_ff <= {wireSync_ff[1:0], wiringCfgPin};
      if (clkSync_ff[1] == clkSync_ff[2])
        linkClkLvl_ff <= clkSync_ff[2];
      if (wireSync_ff[1] == wireSync_ff[2])
        wiringCfgBit_ff <= wireSync_ff[2];
    end
  end

  // ****************************************************************
  // control register and programmable register copy
  // ****************************************************************
  reg        powerSavingSelect_ff;
  reg [17:0] otpReg_ff;
  always @(posedge clk) begin
    if (!rst_b) begin
      powerSavingSelect_ff <= 1'b0;
      otpReg_ff            <= `ATSOV_OTP_RESET;
    end else begin
      if (regWr && regAddr == `ATSOV_ADDR_CTRL)
        powerSavingSelect_ff <= regWdata[`ATSOV_CTRL_PWRSAVE];
      // soft write of the register copy; the sensitivity field keeps its
      // four-step encoding, 00 lowest and 11 highest
      if (regWr && regAddr == `ATSOV_ADDR_OTP)
        otpReg_ff <= regWdata[`ATSOV_OTP_MSB:0];
    end
  end

  // ****************************************************************
  // tracking converter
  // ****************************************************************
  reg [15:0] trackCnt_ff;
  wire       trackTick = (trackCnt_ff == TRACK_CYC[15:0] - 16'h0001);
  wire [7:0] diff = absDiff(angle_ff, measAngle);
  wire       upward = ((measAngle - angle_ff) & 8'h80) == 8'h00;
  always @(posedge clk) begin
    if (!rst_b) begin
      trackCnt_ff <= 16'h0000;
      angle_ff    <= 8'h00;
      locked_ff   <= 1'b0;
    end else if (!powerSavingSelect_ff) begin
      trackCnt_ff <= trackTick ? 16'h0000 : trackCnt_ff + 16'h0001;
      if (trackTick) begin
        // one step per tracking cycle, short way round the circle;
        // relock time then scales with the angle moved while frozen
        if (angle_ff != measAngle)
          angle_ff <= upward ? angle_ff + 8'h01 : angle_ff - 8'h01;
        locked_ff <= (diff <= 8'h01);
      end else if (diff > 8'h01 && diff < 8'hFF) begin
        locked_ff <= 1'b0;
      end
    end else if (diff > 8'h01 && diff < 8'hFF) begin
      // position frozen, but a magnet moved away still drops lock
      locked_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // weak field output
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b)
      weakFieldFlag_ff <= 1'b0;
    else
      weakFieldFlag_ff <= (gainCode == `ATSOV_GAIN_MAX);
  end

  // ****************************************************************
  // serial shifter: digital readback, angle frame, analog readback
  // ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_DIG  = 2'h1;
  localparam ST_ANA  = 2'h2;
  reg [1:0]  state_ff;
  reg [17:0] shift_ff;
  reg [4:0]  bitCnt_ff;
  // angle frame: D15:D14 status, D13:D7 gain code (D13 zero pad), D6:D0 angle msbs
  wire [17:0] angFrame = {2'h0, locked_ff, wiringCfgBit_ff, 1'b0, gainCode, angle_ff[7:1]};
  always @(posedge clk) begin
    if (!rst_b) begin
      state_ff        <= ST_IDLE;
      shift_ff        <= 18'h00000;
      bitCnt_ff       <= 5'h00;
      linkDataOut_ff  <= 1'b0;
      linkDataOe_b_ff <= 1'b1;
      progPinOut_ff   <= 1'b0;
      progPinOe_b_ff  <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (regWr && regAddr == `ATSOV_ADDR_CMD) begin
            if (regWdata[4:0] == `ATSOV_CMD_RD_OTP) begin
              shift_ff  <= otpReg_ff;
              bitCnt_ff <= `ATSOV_OTP_BITS;
              state_ff  <= ST_DIG;
            end else if (regWdata[4:0] == `ATSOV_CMD_RD_ANGLE) begin
              shift_ff  <= angFrame << 2;
              bitCnt_ff <= `ATSOV_ANG_FRAME_BITS;
              state_ff  <= ST_DIG;
            end else if (regWdata[4:0] == `ATSOV_CMD_ANA_OTP) begin
              shift_ff       <= otpReg_ff;
              bitCnt_ff      <= `ATSOV_OTP_BITS;
              progPinOe_b_ff <= 1'b0;
              state_ff       <= ST_ANA;
            end
          end
        end
        ST_DIG: begin
          linkDataOe_b_ff <= 1'b0;
          if (linkRise) begin
            if (bitCnt_ff == 5'h00) begin
              linkDataOe_b_ff <= 1'b1;
              state_ff        <= ST_IDLE;
            end else begin
              linkDataOut_ff <= shift_ff[`ATSOV_OTP_MSB];
              shift_ff       <= {shift_ff[16:0], 1'b0};
              bitCnt_ff      <= bitCnt_ff - 5'h01;
            end
          end
        end
        ST_ANA: begin
          if (linkRise) begin
            if (bitCnt_ff == 5'h00) begin
              progPinOe_b_ff <= 1'b1;
              state_ff       <= ST_IDLE;
            end else begin
              // a one bit pulls the pin low, a zero drives it high
              progPinOut_ff <= ~shift_ff[`ATSOV_OTP_MSB];
              shift_ff      <= {shift_ff[16:0], 1'b0};
              bitCnt_ff     <= bitCnt_ff - 5'h01;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b)
      regRdata_ff <= 32'h00000000;
    else if (regRd) begin
      case (regAddr)
        `ATSOV_ADDR_CTRL:   regRdata_ff <= {31'h0, powerSavingSelect_ff};
        `ATSOV_ADDR_STATUS: regRdata_ff <= {28'h0, state_ff != ST_IDLE, weakFieldFlag_ff,
                                            wiringCfgBit_ff, locked_ff};
        `ATSOV_ADDR_ANGLE:  regRdata_ff <= {18'h0, gainCode, angle_ff};
        `ATSOV_ADDR_OTP:    regRdata_ff <= {14'h0, otpReg_ff};
        default:            regRdata_ff <= 32'h00000000;
      endcase
    end else
      regRdata_ff <= 32'h00000000;
  end
endmodule // atsov_top

// ---- atsov_checker.sv ----
// assertions on lock, weak field, read data and readback start
`timescale 1ns/1ps
`include "atsov_regs.vh"
module atsov_checker #(
  parameter TRACK_CYC = 4
) (
  input wire        clk,
  input wire        rst_b,
  input wire [3:0]  regAddr,
  input wire [31:0] regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [31:0] regRdata_ff,
  input wire        linkDataOe_b_ff,
  input wire        progPinOe_b_ff,
  input wire [7:0]  measAngle,
  input wire [5:0]  gainCode,
  input wire        weakFieldFlag_ff,
  input wire [7:0]  angle_ff,
  input wire        locked_ff
);
  // ****
  // helpers
  // ****
  wire [7:0] diff  = angle_ff - measAngle;
  wire       cmdWr = regWr && regAddr == `ATSOV_ADDR_CMD;
  reg [15:0] gapCnt_ff;
  // cycles since the converter last moved; saturates so long holds never wrap
  always @(posedge clk) begin
    if (!rst_b || $changed(angle_ff)) gapCnt_ff <= 16'h0000;
    else if (gapCnt_ff != 16'hFFFF) gapCnt_ff <= gapCnt_ff + 16'h0001;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_weak_set: assert property (gainCode == `ATSOV_GAIN_MAX |=> weakFieldFlag_ff)
    else $error("weak flag low at top gain");
  chk_weak_clr: assert property (gainCode != `ATSOV_GAIN_MAX |=> !weakFieldFlag_ff)
    else $error("weak flag high below top gain");
  chk_rdata_idle: assert property (!regRd |=> regRdata_ff == 32'h00000000)
    else $error("read data outside read answer");
  chk_link_start: assert property ($fell(linkDataOe_b_ff) |-> $past(cmdWr, 2))
    else $error("link driven without command");
  chk_program_voltage_pin_start: assert property ($fell(progPinOe_b_ff) |->
    $past(cmdWr && regWdata[4:0] == `ATSOV_CMD_ANA_OTP))
    else $error("program pin driven without analog command");
  chk_track_step: assert property ($changed(angle_ff) |->
    (angle_ff - $past(angle_ff)) == 8'h01 || (angle_ff - $past(angle_ff)) == 8'hFF)
    else $error("converter moved more than one step");
  chk_step_gap: assert property ($changed(angle_ff) |-> gapCnt_ff >= TRACK_CYC - 1)
    else $error("converter stepped faster than tracking cycle");
  chk_lock_drop: assert property (diff > 8'h01 && diff < 8'hFF |-> ##[0:1] !locked_ff)
    else $error("lock kept while far from angle");
  cov_weak: cover property ($rose(weakFieldFlag_ff));
  cov_lock: cover property ($rose(locked_ff));
  cov_ana: cover property ($fell(progPinOe_b_ff));
endmodule // atsov_checker
bind atsov_top atsov_checker #(.TRACK_CYC(TRACK_CYC)) i_chk (.clk(clk), .rst_b(rst_b),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata_ff(regRdata_ff), .linkDataOe_b_ff(linkDataOe_b_ff), .progPinOe_b_ff(progPinOe_b_ff),
  .measAngle(measAngle), .gainCode(gainCode), .weakFieldFlag_ff(weakFieldFlag_ff),
  .angle_ff(angle_ff), .locked_ff(locked_ff));

// ---- atsov_host_model.sv ----
// host model that clocks the serial link and collects returned bits
`timescale 1ns/1ps
module atsov_host_model (
  input wire  linkDataOut_ff,
  input wire  linkDataOe_b_ff,
  input wire  progPinOut_ff,
  input wire  progPinOe_b_ff,
  output reg  linkClk
);
  initial linkClk = 1'b0; // clock stands still between frames
  // an undriven line reads as unknown so it can never pass for a bit
  task automatic xfer(input int n, input bit ana, output logic [17:0] got);
    got = '0;
    // each rise shifts a bit out a few cycles later, so sample late in the high phase
    repeat (n) begin
      linkClk = 1'b1;
      #80;
      got = {got[16:0], ana ? (progPinOe_b_ff ? 1'bx : ~progPinOut_ff)
                            : (linkDataOe_b_ff ? 1'bx : linkDataOut_ff)};
      linkClk = 1'b0;
      #80;
    end
    #80 linkClk = 1'b1; // one more edge ends the frame
    #80 linkClk = 1'b0;
  endtask
endmodule // atsov_host_model

// ---- tb_atsov_top.sv ----
// self-checking bench for the tracker status and readback block
`timescale 1ns/1ps
`include "atsov_regs.vh"
module tb_atsov_top;
  logic        clk, rst_b, regWr, regRd, wiringCfgPin;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, v;
  logic [7:0]  measAngle;
  logic [5:0]  gainCode;
  logic [17:0] got;
  wire  [31:0] regRdata_ff;
  wire  [7:0]  angle_ff;
  wire         linkClk, linkDataOut_ff, linkDataOe_b_ff, progPinOut_ff, progPinOe_b_ff;
  wire         weakFieldFlag_ff, locked_ff;
  int          errors, checks_done, n;
  atsov_top #(.TRACK_CYC(4)) i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff),
    .linkClk(linkClk), .linkDataOut_ff(linkDataOut_ff), .linkDataOe_b_ff(linkDataOe_b_ff),
    .progPinOut_ff(progPinOut_ff), .progPinOe_b_ff(progPinOe_b_ff),
    .wiringCfgPin(wiringCfgPin), .measAngle(measAngle), .gainCode(gainCode),
    .weakFieldFlag_ff(weakFieldFlag_ff), .angle_ff(angle_ff), .locked_ff(locked_ff));
  atsov_host_model i_host (.linkDataOut_ff(linkDataOut_ff), .linkDataOe_b_ff(linkDataOe_b_ff),
    .progPinOut_ff(progPinOut_ff), .progPinOe_b_ff(progPinOe_b_ff), .linkClk(linkClk));
  // ****
  // tasks
  // ****
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata_ff;
    @(posedge clk);
  endtask
  task waitLock;
    n = 0;
    while (locked_ff !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 600) begin
        errors++;
        give_verdict;
      end
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0; regAddr = 4'h0; regWdata = 32'h0; regWr = 1'b0; regRd = 1'b0;
    wiringCfgPin = 1'b0; measAngle = 8'h00; gainCode = 6'h20;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`ATSOV_ADDR_OTP);
    chk("otp reset", v, 32'h0);
    rd(4'hF);
    chk("unmapped", v, 32'h0);
    for (int i = 1; i >= 0; i--) begin
      wiringCfgPin <= i[0];
      repeat (6) @(posedge clk);
      rd(`ATSOV_ADDR_STATUS);
      chk("wiring", v[`ATSOV_ST_WIRE], i[0]);
    end
    gainCode <= 6'h3F;
    repeat (3) @(posedge clk);
    chk("weak hi", weakFieldFlag_ff, 1'b1);
    gainCode <= 6'h3E;
    measAngle <= 8'h40;
    repeat (3) @(posedge clk);
    chk("weak lo", weakFieldFlag_ff, 1'b0);
    waitLock;
    chk("lock time", n >= 240 && n <= 270, 1'b1);
    rd(`ATSOV_ADDR_ANGLE);
    chk("angle reg", v, 32'h3E40);
    rd(`ATSOV_ADDR_STATUS);
    chk("lock bit", v[`ATSOV_ST_LOCK], 1'b1);
    wr(`ATSOV_ADDR_CTRL, 32'h1);
    measAngle <= 8'h60;
    repeat (40) @(posedge clk);
    chk("frozen", {locked_ff, angle_ff}, 9'h040);
    wr(`ATSOV_ADDR_CTRL, 32'h0);
    waitLock;
    chk("relock", n >= 112 && n <= 140, 1'b1);
    gainCode <= 6'h20;
    repeat (2) @(posedge clk);
    rd(`ATSOV_ADDR_STATUS);
    chk("accept lock", v[`ATSOV_ST_LOCK], 1'b1);
    rd(`ATSOV_ADDR_ANGLE);
    chk("accept angle", v, 32'h2060);
    gainCode <= 6'h24;
    repeat (2) @(posedge clk);
    rd(`ATSOV_ADDR_ANGLE);
    chk("push gain", v[13:8] != 6'h20, 1'b1);
    wr(`ATSOV_ADDR_OTP, 32'h003A5);
    rd(`ATSOV_ADDR_OTP);
    chk("otp soft", v, 32'h003A5);
    wr(`ATSOV_ADDR_CMD, `ATSOV_CMD_RD_OTP);
    i_host.xfer(18, 1'b0, got);
    chk("digital", got, 18'h003A5);
    repeat (8) @(posedge clk);
    wr(`ATSOV_ADDR_CMD, `ATSOV_CMD_ANA_OTP);
    i_host.xfer(18, 1'b1, got);
    chk("analog", got, 18'h003A5);
    repeat (8) @(posedge clk);
    chk("released", {linkDataOe_b_ff, progPinOe_b_ff}, 2'b11);
    wr(`ATSOV_ADDR_CMD, `ATSOV_CMD_RD_ANGLE);
    i_host.xfer(16, 1'b0, got);
    chk("angle frame", got, 18'h09230);
    repeat (8) @(posedge clk);
    chk("frame end", linkDataOe_b_ff, 1'b1);
    give_verdict;
  end
endmodule // tb_atsov_top
